/* verilog/cmp_trig_pkg.sv */
// constants for the four-channel compare queue and trigger router
// assumes one system clock and a plain strobe register port
package cmp_trig_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 32;
    localparam int QUEUE_DEPTH = 1023;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 8;
    // register index = {reg[5:0], channel[1:0]}
    localparam logic [5:0] REG_TRIG_CFG = 6'h00;
    localparam logic [5:0] REG_LEVEL_OUT = 6'h01;
    localparam logic [5:0] REG_COMPARE = 6'h02;
    localparam logic [5:0] REG_QUEUE_DATA = 6'h03;
    localparam logic [5:0] REG_QUEUE_CTRL = 6'h04;
    localparam logic [5:0] REG_QUEUE_STAT = 6'h05;
    localparam logic [5:0] REG_POSITION = 6'h06;
    // trigger config fields
    localparam int TC_SEL = 0;
    localparam int TC_POL = 1;
    localparam int TC_COMPARE_SOURCE_ENABLE = 2;
    localparam int TC_PMASK = 4;
    localparam int TC_LMASK = 8;
    localparam int TC_IMASK = 12;
    // level output fields
    localparam int LO_SRC = 0;
    localparam int LO_VAL = 1;
    // queue control fields
    localparam int QC_RESET = 0;
    localparam int QC_SHIFT = 1;
    localparam int QC_LEVEL = 4;
    // queue fill state codes
    localparam logic [1:0] FILL_EMPTY = 2'h0;
    localparam logic [1:0] FILL_LOW = 2'h1;
    localparam logic [1:0] FILL_MID = 2'h2;
    localparam logic [1:0] FILL_FULL = 2'h3;
    localparam logic [1:0] LEVEL_RESET = 2'h2;
    localparam logic [CNT_W-1:0] LEVEL_STEP = 10'h100;
endpackage : cmp_trig_pkg

/* verilog/compare_queue.sv */
// one channel: compare queue feeding a compare register
// assumes push, shift and reset strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module compare_queue
    import cmp_trig_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int WIDTH = DATA_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic clear,
    input wire logic shift,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_data,
    input wire logic [WIDTH-1:0] position,
    input wire logic [1:0] level_sel,
    output logic [WIDTH-1:0] compare_q,
    output logic [1:0] fill_state,
    output logic match_q
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CNT_W-1:0] wr_q, rd_q, cnt_q;
    logic [CNT_W-1:0] low_level;
    logic full, empty, hit, pop, do_push;

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] p);
        return (p == CNT_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign full = (cnt_q == CNT_W'(DEPTH));
    assign empty = (cnt_q == '0);
    assign hit = (position == compare_q);
    // R23 auto reload on match
    assign pop = (shift | (hit & ~match_q)) & ~empty & ~clear;
    // R14 full write dropped
    assign do_push = push & ~full & ~clear;
    // R17 threshold select
    assign low_level = CNT_W'(level_sel) * LEVEL_STEP;
    // R12 fill state code
    assign fill_state = empty ? FILL_EMPTY : full ? FILL_FULL :
                        (cnt_q <= low_level) ? FILL_LOW : FILL_MID;

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            compare_q <= '0;
            match_q <= 1'b0;
        end else begin
            match_q <= hit;
            // R11 reset empties queue
            if (clear) begin
                wr_q <= '0;
                rd_q <= '0;
                cnt_q <= '0;
            end else begin
                if (do_push) begin
                    wr_q <= bump(wr_q);
                end
                if (pop) begin
                    rd_q <= bump(rd_q);
                end
                cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(pop);
            end
            // R9 software override wins
            if (load) begin
                compare_q <= load_data;
            // R15 shift loads oldest
            end else if (pop) begin
                compare_q <= mem[rd_q];
            end
        end
    end
endmodule : compare_queue
`default_nettype wire

/* verilog/compare_fifo_trigger_router.sv */
// four-channel compare queues with trigger and level output routing
// assumes pin inputs are asynchronous; register port on clk_sys
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: source select: switch bank or masks
// R2: switch bank selected ignores all masks
// R3: mask source ORs selected inputs
// R4: mask bit n selects channel n
// R5: trigger polarity selectable per channel
// R6: level output: software or follow trigger
// R7: inversion applies to trigger only
// R8: software level 0 low, 1 high
// R9: software overwrites compare register
// R10: compare register readable
// R11: queue reset empties the queue
// R12: two-bit fill state encoding
// R13: queue holds 1023 entries
// R14: full queue drops writes, no stall
// R15: shift loads oldest entry into compare
// R16: software shifts once before comparing
// R17: low level select 0/256/512/768
// R18: low level resets to 512
// R19: low level select readable
// R20: block writes push in array order
// R21: four channels, index 0 to 3
// R22: match feeds pulse when enabled
// R23: match reloads next queue entry
// R24: config changes act next cycle
module compare_fifo_trigger_router
    import cmp_trig_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [CH*DATA_W-1:0] position_in,
    input wire logic [CH-1:0] pulse_in,
    input wire logic [CH-1:0] level_in,
    input wire logic [CH-1:0] index_input,
    input wire logic [CH-1:0] default_switch_bank,
    output logic [CH-1:0] compare_pulse,
    output logic [CH-1:0] trigger_output,
    output logic [CH-1:0] level_output
);
    logic [CH-1:0] pulse_s1, pulse_s2, lvl_s1, lvl_s2, idx_s1, idx_s2, sw_s1, sw_s2;
    logic [CH-1:0] trigger_source_select_q, polarity_q, compare_source_enable_q;
    logic [CH-1:0] level_output_source_q, level_output_value_q;
    logic [CH-1:0] pulse_source_mask_q [CH];
    logic [CH-1:0] level_input_source_mask_q [CH];
    logic [CH-1:0] index_source_mask_q [CH];
    logic [1:0] level_sel_q [CH];
    logic [DATA_W-1:0] compare_value [CH];
    logic [1:0] queue_fill_state [CH];
    logic [CH-1:0] match;
    logic [CH-1:0] trig_raw, trig_out_d, lvl_out_d;
    logic [CH-1:0] ch_hit, wr_cfg, wr_lvl, wr_cmp, wr_data, wr_ctrl;
    logic [5:0] reg_sel;
    logic [1:0] ch_idx;
    logic [DATA_W-1:0] rdata_d;

    // R21 channel index decode
    assign reg_sel = reg_addr[ADDR_W-1:2];
    assign ch_idx = reg_addr[1:0];

    // pin inputs through two flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_s1 <= '0;
            pulse_s2 <= '0;
            lvl_s1 <= '0;
            lvl_s2 <= '0;
            idx_s1 <= '0;
            idx_s2 <= '0;
            sw_s1 <= '0;
            sw_s2 <= '0;
        end else begin
            pulse_s1 <= pulse_in;
            pulse_s2 <= pulse_s1;
            lvl_s1 <= level_in;
            lvl_s2 <= lvl_s1;
            idx_s1 <= index_input;
            idx_s2 <= idx_s1;
            sw_s1 <= default_switch_bank;
            sw_s2 <= sw_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            assign ch_hit[g] = (ch_idx == 2'(g));
            assign wr_cfg[g] = reg_write & ch_hit[g] & (reg_sel == REG_TRIG_CFG);
            assign wr_lvl[g] = reg_write & ch_hit[g] & (reg_sel == REG_LEVEL_OUT);
            assign wr_cmp[g] = reg_write & ch_hit[g] & (reg_sel == REG_COMPARE);
            assign wr_data[g] = reg_write & ch_hit[g] & (reg_sel == REG_QUEUE_DATA);
            assign wr_ctrl[g] = reg_write & ch_hit[g] & (reg_sel == REG_QUEUE_CTRL);

            // R13 queue depth
            compare_queue #(
                .DEPTH(DEPTH),
                .WIDTH(DATA_W)
            ) compare_queue_i (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .push(wr_data[g]),
                .push_data(reg_wdata),
                .clear(wr_ctrl[g] & reg_wdata[QC_RESET]),
                .shift(wr_ctrl[g] & reg_wdata[QC_SHIFT]),
                .load(wr_cmp[g]),
                .load_data(reg_wdata),
                .position(position_in[g*DATA_W +: DATA_W]),
                .level_sel(level_sel_q[g]),
                .compare_q(compare_value[g]),
                .fill_state(queue_fill_state[g]),
                .match_q(match[g])
            );

            // R3 OR of masked sources
            // R4 bit n is channel n
            assign trig_raw[g] = trigger_source_select_q[g]
                ? (|(pulse_s2 & pulse_source_mask_q[g]) |
                   |(lvl_s2 & level_input_source_mask_q[g]) |
                   |(idx_s2 & index_source_mask_q[g]))
                // R2 masks ignored here
                : sw_s2[g];
            // R5 polarity applied
            assign trig_out_d[g] = trig_raw[g] ^ polarity_q[g];
            // R6 level output source
            // R7 follows uninverted trigger
            // R8 software level drive
            assign lvl_out_d[g] = level_output_source_q[g] ? trig_raw[g] : level_output_value_q[g];

            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    pulse_source_mask_q[g] <= '0;
                    level_input_source_mask_q[g] <= '0;
                    index_source_mask_q[g] <= '0;
                    // R18 default 512 level
                    level_sel_q[g] <= LEVEL_RESET;
                end else begin
                    if (wr_cfg[g]) begin
                        pulse_source_mask_q[g] <= reg_wdata[TC_PMASK +: CH];
                        level_input_source_mask_q[g] <= reg_wdata[TC_LMASK +: CH];
                        index_source_mask_q[g] <= reg_wdata[TC_IMASK +: CH];
                    end
                    if (wr_ctrl[g]) begin
                        level_sel_q[g] <= reg_wdata[QC_LEVEL +: 2];
                    end
                end
            end
        end
    endgenerate

    // per-channel control bits
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trigger_source_select_q <= '0;
            polarity_q <= '0;
            compare_source_enable_q <= {CH{1'b1}};
            level_output_source_q <= '0;
            level_output_value_q <= '0;
        end else begin
            for (int i = 0; i < CH; i++) begin
                // R1 source select written
                if (wr_cfg[i]) begin
                    trigger_source_select_q[i] <= reg_wdata[TC_SEL];
                    polarity_q[i] <= reg_wdata[TC_POL];
                    compare_source_enable_q[i] <= reg_wdata[TC_COMPARE_SOURCE_ENABLE];
                end
                if (wr_lvl[i]) begin
                    level_output_source_q[i] <= reg_wdata[LO_SRC];
                    level_output_value_q[i] <= reg_wdata[LO_VAL];
                end
            end
        end
    end

    // R24 outputs registered
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trigger_output <= '0;
            level_output <= '0;
            compare_pulse <= '0;
        end else begin
            trigger_output <= trig_out_d;
            level_output <= lvl_out_d;
            // R22 gated compare match
            compare_pulse <= match & compare_source_enable_q;
        end
    end

    // read mux
    always_comb begin
        rdata_d = '0;
        case (reg_sel)
            REG_TRIG_CFG: begin
                rdata_d[TC_SEL] = trigger_source_select_q[ch_idx];
                rdata_d[TC_POL] = polarity_q[ch_idx];
                rdata_d[TC_COMPARE_SOURCE_ENABLE] = compare_source_enable_q[ch_idx];
                rdata_d[TC_PMASK +: CH] = pulse_source_mask_q[ch_idx];
                rdata_d[TC_LMASK +: CH] = level_input_source_mask_q[ch_idx];
                rdata_d[TC_IMASK +: CH] = index_source_mask_q[ch_idx];
            end
            REG_LEVEL_OUT: begin
                rdata_d[LO_SRC] = level_output_source_q[ch_idx];
                rdata_d[LO_VAL] = level_output_value_q[ch_idx];
            end
            // R10 compare readback
            REG_COMPARE: rdata_d = compare_value[ch_idx];
            // R19 level select readback
            REG_QUEUE_CTRL: rdata_d[QC_LEVEL +: 2] = level_sel_q[ch_idx];
            REG_QUEUE_STAT: rdata_d[1:0] = queue_fill_state[ch_idx];
            REG_POSITION: rdata_d = position_in[ch_idx*DATA_W +: DATA_W];
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : compare_fifo_trigger_router
`default_nettype wire

/* tb/router_monitor.sv */
// port checker for the compare queue and trigger router
// assumes the register index layout of cmp_trig_pkg
`timescale 1ns/1ps
`default_nettype none
module router_monitor
    import cmp_trig_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [CH-1:0] compare_pulse,
    input wire logic [CH-1:0] trigger_output,
    input wire logic [CH-1:0] level_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic [5:0] reg_sel = reg_addr[ADDR_W-1:2];
    sequence s_rd(logic [5:0] r);
        reg_read && reg_sel == r;
    endsequence
    sequence s_wr(logic [5:0] r, logic ok);
        reg_write && reg_sel == r && ok;
    endsequence
    property p_rdata_idle;
        !reg_read |=> reg_rdata == '0;
    endproperty
    property p_stat_width;
        s_rd(REG_QUEUE_STAT) |=> reg_rdata[DATA_W-1:2] == '0;
    endproperty
    property p_unmapped;
        reg_read && reg_sel > REG_POSITION |=> reg_rdata == '0;
    endproperty
    property p_cmp_back;
        s_wr(REG_COMPARE, 1'b1) ##1 s_rd(REG_COMPARE) ##0 reg_addr == $past(reg_addr)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_level_sw;
        s_wr(REG_LEVEL_OUT, !reg_wdata[LO_SRC])
            |=> ##1 level_output[$past(reg_addr[1:0], 2)] == $past(reg_wdata[LO_VAL], 2);
    endproperty
    property p_mask_zero;
        s_wr(REG_TRIG_CFG, reg_wdata[TC_SEL] && reg_wdata[TC_IMASK+3:TC_PMASK] == '0)
            |=> ##1 trigger_output[$past(reg_addr[1:0], 2)] == $past(reg_wdata[TC_POL], 2);
    endproperty
    property p_cmp_off;
        s_wr(REG_TRIG_CFG, !reg_wdata[TC_COMPARE_SOURCE_ENABLE]) |=> ##1 !compare_pulse[$past(reg_addr[1:0], 2)];
    endproperty
    property p_clear;
        s_wr(REG_QUEUE_CTRL, reg_wdata[QC_RESET]) ##1 s_rd(REG_QUEUE_STAT)
            ##0 reg_addr[1:0] == $past(reg_addr[1:0]) |=> reg_rdata[1:0] == FILL_EMPTY;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero when idle");
    a_stat_width: assert property (p_stat_width)
        else $error("fill state wider than two bits");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_cmp_back: assert property (p_cmp_back)
        else $error("compare readback differs from write");
    a_level_sw: assert property (p_level_sw)
        else $error("software level output wrong");
    a_mask_zero: assert property (p_mask_zero)
        else $error("empty masks not at polarity level");
    a_cmp_off: assert property (p_cmp_off)
        else $error("compare pulse while disabled");
    a_clear: assert property (p_clear)
        else $error("queue not empty after clear");
endmodule : router_monitor
bind compare_fifo_trigger_router router_monitor #(.CH(CH), .DEPTH(DEPTH)) router_monitor_i (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .compare_pulse, .trigger_output, .level_output
);
`default_nettype wire

/* tb/trigger_sink.sv */
// equipment model counting rising trigger edges
// assumes trigger outputs are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module trigger_sink
    import cmp_trig_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [NUM_CH-1:0] trigger_output,
    output var int edges
);
    logic [NUM_CH-1:0] trig_q;
    always_ff @(posedge clk_sys) begin
        trig_q <= trigger_output;
        edges <= edges + $countones(trigger_output & ~trig_q);
    end
endmodule : trigger_sink
`default_nettype wire

/* tb/compare_fifo_trigger_router_test.sv */
// self-checking bench for the compare queue and trigger router
// assumes 50 MHz clk_sys and the strobe register port
`timescale 1ns/1ps
`default_nettype none
module compare_fifo_trigger_router_test
    import cmp_trig_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_CH*DATA_W-1:0] position_in = {NUM_CH{32'hFFFF_FFF0}};
    logic [NUM_CH-1:0] pulse_in = '0;
    logic [NUM_CH-1:0] level_in = '0;
    logic [NUM_CH-1:0] index_input = '0;
    logic [NUM_CH-1:0] default_switch_bank = '0;
    logic [NUM_CH-1:0] compare_pulse;
    logic [NUM_CH-1:0] trigger_output;
    logic [NUM_CH-1:0] level_output;
    int miscompares = 0;
    int n_tests = 0;
    int sink_edges;
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    compare_fifo_trigger_router compare_fifo_trigger_router_i (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .position_in, .pulse_in, .level_in, .index_input, .default_switch_bank,
        .compare_pulse, .trigger_output, .level_output
    );
    trigger_sink trigger_sink_i (.clk_sys, .trigger_output, .edges(sink_edges));
    task give_verdict;
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [5:0] r, input logic [1:0] c, input logic [31:0] d);
        if (!clk_sys) @(posedge clk_sys);
        reg_addr <= {r, c};
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task rd(input logic [5:0] r, input logic [1:0] c, input logic [31:0] e);
        if (!clk_sys) @(posedge clk_sys);
        reg_addr <= {r, c};
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask : rd
    task settle(input int n);
        reg_write <= 1'b0;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    // pins are {pulse, level, index, switch bank}; channel 1 observed
    task trg(input logic [15:0] cfg, input logic [15:0] pins, input logic e);
        if (!clk_sys) @(posedge clk_sys);
        {pulse_in, level_in, index_input, default_switch_bank} <= pins;
        wr(REG_TRIG_CFG, 2'h1, {16'h0000, cfg});
        settle(4);
        chk(trigger_output[1], e);
    endtask : trg
    task reset_values;
        int c;
        for (c = 0; c < NUM_CH; c++) begin
            rd(REG_QUEUE_CTRL, c[1:0], 32'h20);
            rd(REG_QUEUE_STAT, c[1:0], 32'h0);
        end
        rd(6'h3F, 2'h0, 32'h0);
    endtask : reset_values
    task routing;
        trg(16'h0FF0, 16'h0002, 1'b1);
        trg(16'h0FF0, 16'hFFF0, 1'b0);
        trg(16'h0003, 16'hFFFF, 1'b1);
        trg(16'h0021, 16'h2000, 1'b1);
        trg(16'h0021, 16'h1000, 1'b0);
        trg(16'h0601, 16'h0400, 1'b1);
        trg(16'h1001, 16'h0010, 1'b1);
        trg(16'h1003, 16'h0010, 1'b0);
        trg(16'h1003, 16'h0020, 1'b1);
    endtask : routing
    task level_out;
        wr(REG_LEVEL_OUT, 2'h1, 32'h1);
        settle(2);
        chk(level_output[1], 1'b0);
        wr(REG_LEVEL_OUT, 2'h1, 32'h2);
        settle(2);
        chk(level_output[1], 1'b1);
        wr(REG_LEVEL_OUT, 2'h1, 32'h0);
        settle(2);
        chk(level_output[1], 1'b0);
    endtask : level_out
    task queue_fill;
        int i;
        wr(REG_QUEUE_CTRL, 2'h3, 32'h01);
        wr(REG_QUEUE_DATA, 2'h3, 32'h0);
        rd(REG_QUEUE_STAT, 2'h3, 32'h2);
        wr(REG_QUEUE_CTRL, 2'h3, 32'h31);
        rd(REG_QUEUE_STAT, 2'h3, 32'h0);
        for (i = 0; i < 1024; i++) begin
            if (i == 768) rd(REG_QUEUE_STAT, 2'h3, 32'h1);
            if (i == 769) rd(REG_QUEUE_STAT, 2'h3, 32'h2);
            wr(REG_QUEUE_DATA, 2'h3, i);
        end
        rd(REG_QUEUE_STAT, 2'h3, 32'h3);
        for (i = 0; i < 1024; i++) wr(REG_QUEUE_CTRL, 2'h3, 32'h32);
        rd(REG_COMPARE, 2'h3, 32'h3FE);
        rd(REG_QUEUE_STAT, 2'h3, 32'h0);
    endtask : queue_fill
    task match_reload;
        int k;
        wr(REG_QUEUE_CTRL, 2'h0, 32'h21);
        wr(REG_QUEUE_DATA, 2'h0, 32'h64);
        wr(REG_QUEUE_DATA, 2'h0, 32'hC8);
        wr(REG_QUEUE_CTRL, 2'h0, 32'h22);
        rd(REG_COMPARE, 2'h0, 32'h64);
        @(posedge clk_sys);
        position_in[31:0] <= 32'h64;
        for (k = 0; k < 8 && compare_pulse[0] !== 1'b1; k++) @(negedge clk_sys);
        chk(k < 8, 1'b1);
        if (k == 8) begin
            give_verdict();
        end
        rd(REG_COMPARE, 2'h0, 32'hC8);
        rd(REG_POSITION, 2'h0, 32'h64);
        wr(REG_TRIG_CFG, 2'h0, 32'h0);
        position_in[31:0] <= 32'hC8;
        settle(6);
        chk(compare_pulse[0], 1'b0);
        wr(REG_COMPARE, 2'h2, 32'h1234_5678);
        rd(REG_COMPARE, 2'h2, 32'h1234_5678);
    endtask : match_reload
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        reset_values();
        routing();
        level_out();
        queue_fill();
        match_reload();
        chk(sink_edges != 0, 1'b1);
        give_verdict();
    end
endmodule : compare_fifo_trigger_router_test
`default_nettype wire
